// ### logic/low_power_pin_function_mux.sv
`timescale 1ns/1ps
`include "lp_pin_defines.svh"
module low_power_pin_function_mux
   import lp_pin_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // power state and ownership
   input wire logic deep_sleep,
   input wire logic lp_claim,
   // select configuration port
   input wire logic cfg_we,
   input wire logic [2:0] cfg_index,
   input wire logic [1:0] cfg_func,
   input wire logic usb_cfg_we,
   input wire logic usb_cfg_gpio,
   input wire logic debug_from_usb,
   // low-power pads
   input wire logic [`LP_PIN_COUNT-1:0] pad_in,
   output pad_drive_s pad_q,
   // main pin selector side
   input wire pad_drive_s main_drive,
   output logic [`LP_PIN_COUNT-1:0] main_in_q,
   output logic main_selector_active_q,
   // low-power processor general io
   input wire pad_drive_s low_power_general_io,
   output logic [`LP_PIN_COUNT-1:0] low_power_general_io_in_q,
   // low-power uart
   input wire logic lpuart_terminal_ready_n,
   input wire logic lpuart_request_send_n,
   input wire logic lpuart_transmit_line,
   output uart_in_s lpuart_in_q,
   // low-power two-wire bus, open drain
   input wire logic lp_twowire_data_low,
   input wire logic lp_twowire_clock_low,
   output logic lp_twowire_data_in_q,
   output logic lp_twowire_clock_in_q,
   // usb data pads
   input wire logic [1:0] usb_pad_in,
   input wire logic [1:0] usb_ctrl_out,
   input wire logic [1:0] usb_ctrl_oe,
   input wire logic [1:0] usb_gpio_out,
   input wire logic [1:0] usb_gpio_oe,
   output logic [1:0] usb_pad_out_q,
   output logic [1:0] usb_pad_oe_q,
   output logic [1:0] usb_ctrl_in_q,
   output logic [1:0] usb_gpio_in_q,
   // debug port and analog status
   output logic test_pins_free_q,
   output logic analog_available_q
);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [`LP_PIN_COUNT-1:0] pad_meta_q;
   logic [`LP_PIN_COUNT-1:0] pad_sync_q;
   logic [1:0] usb_meta_q;
   logic [1:0] usb_sync_q;

   // pads are asynchronous to clk, two stages before use
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pad_meta_q <= '0;
         pad_sync_q <= '0;
         usb_meta_q <= '0;
         usb_sync_q <= '0;
      end
      else
      begin
         pad_meta_q <= pad_in;
         pad_sync_q <= pad_meta_q;
         usb_meta_q <= usb_pad_in;
         usb_sync_q <= usb_meta_q;
      end
   end

   // ----------------------------------------
   // select registers
   // ----------------------------------------
   lp_sel_e sel_q [`LP_PIN_COUNT];
   lp_sel_e sel_d [`LP_PIN_COUNT];
   logic usb_gpio_q;
   logic usb_gpio_d;
   logic owns_d;

   // low-power selector owns the pads in deep sleep or when claimed
   assign owns_d = deep_sleep | lp_claim; // RULE1

   // usb pads stay with the controller until software moves them
   always_comb
   begin
      usb_gpio_d = usb_gpio_q;
      if (usb_cfg_we)
      begin
         usb_gpio_d = usb_cfg_gpio; // RULE9
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `LP_PIN_COUNT; gi++)
      begin : g_sel
         // indexed by low-power io number, not package pin
         always_comb
         begin
            sel_d[gi] = sel_q[gi];
            if (cfg_we && (cfg_index == 3'(gi))) // RULE7
            begin
               sel_d[gi] = lp_sel_e'(cfg_func);
            end
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               sel_q[gi] <= lp_sel_e'(`LP_SEL_RESET);
            end
            else
            begin
               sel_q[gi] <= sel_d[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // pad drive
   // ----------------------------------------
   pad_drive_s pad_d;
   logic [`LP_PIN_COUNT-1:0] gpio_in_d;

   generate
      for (gi = 0; gi < `LP_PIN_COUNT; gi++)
      begin : g_pad
         // exactly one source per pad; deep sleep or a claim switches it from main_drive to the select
         always_comb
         begin
            pad_d.out[gi] = 1'b0;
            pad_d.oe[gi] = 1'b0; // RULE14
            gpio_in_d[gi] = 1'b0;
            if (!owns_d)
            begin
               pad_d.out[gi] = main_drive.out[gi];
               pad_d.oe[gi] = main_drive.oe[gi];
            end
            else
            begin
               unique case (sel_q[gi]) // RULE2
                  SEL_GPIO:
                  begin
                     pad_d.out[gi] = low_power_general_io.out[gi]; // RULE3 RULE6
                     pad_d.oe[gi] = low_power_general_io.oe[gi];
                     gpio_in_d[gi] = pad_sync_q[gi];
                  end
                  SEL_UART:
                  begin
                     // outputs drive, inputs leave the pad floating
                     if (gi == `LP_PIN_DTR)
                     begin
                        pad_d.out[gi] = lpuart_terminal_ready_n; // RULE4 RULE5
                        pad_d.oe[gi] = 1'b1;
                     end
                     if (gi == `LP_PIN_RTS)
                     begin
                        pad_d.out[gi] = lpuart_request_send_n; // RULE5
                        pad_d.oe[gi] = 1'b1;
                     end
                     if (gi == `LP_PIN_TXD)
                     begin
                        pad_d.out[gi] = lpuart_transmit_line; // RULE5
                        pad_d.oe[gi] = 1'b1;
                     end
                  end
                  SEL_TWI:
                  begin
                     // open drain: only ever pulls low
                     if (gi == `LP_PIN_SDA)
                     begin
                        pad_d.oe[gi] = lp_twowire_data_low; // RULE4 RULE6
                     end
                     if (gi == `LP_PIN_SCL)
                     begin
                        pad_d.oe[gi] = lp_twowire_clock_low; // RULE6
                     end
                  end
                  SEL_NONE:
                  begin
                     pad_d.oe[gi] = 1'b0; // RULE14
                  end
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // peripheral inputs
   // ----------------------------------------
   uart_in_s uart_d;
   logic sda_d;
   logic scl_d;
   logic [1:0] usb_pad_out_d;
   logic [1:0] usb_pad_oe_d;

   // pull-high inputs idle at 1 when their function is not selected;
   // pins 2 and 3 serve either rts/cts or the two-wire bus, never both
   always_comb
   begin
      uart_d.set_ready_n = 1'b1; // RULE13
      uart_d.clear_send_n = 1'b1;
      uart_d.receive_line = 1'b1;
      sda_d = 1'b1;
      scl_d = 1'b1;
      if (owns_d)
      begin
         if (sel_q[`LP_PIN_DSR] == SEL_UART)
         begin
            uart_d.set_ready_n = pad_sync_q[`LP_PIN_DSR]; // RULE5
         end
         if (sel_q[`LP_PIN_CTS] == SEL_UART)
         begin
            uart_d.clear_send_n = pad_sync_q[`LP_PIN_CTS]; // RULE5 RULE8
         end
         if (sel_q[`LP_PIN_RXD] == SEL_UART)
         begin
            uart_d.receive_line = pad_sync_q[`LP_PIN_RXD]; // RULE5
         end
         if (sel_q[`LP_PIN_SDA] == SEL_TWI)
         begin
            sda_d = pad_sync_q[`LP_PIN_SDA]; // RULE6 RULE8
         end
         if (sel_q[`LP_PIN_SCL] == SEL_TWI)
         begin
            scl_d = pad_sync_q[`LP_PIN_SCL]; // RULE6
         end
      end
   end

   // usb pads: controller by default, general io after reconfiguration
   always_comb
   begin
      usb_pad_out_d = usb_ctrl_out; // RULE9
      usb_pad_oe_d = usb_ctrl_oe;
      if (usb_gpio_q)
      begin
         usb_pad_out_d = usb_gpio_out;
         usb_pad_oe_d = usb_gpio_oe;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pad_q <= '0;
         main_in_q <= '0;
         main_selector_active_q <= 1'b0;
         low_power_general_io_in_q <= '0;
         lpuart_in_q <= '1;
         lp_twowire_data_in_q <= 1'b1;
         lp_twowire_clock_in_q <= 1'b1;
         usb_gpio_q <= `LP_USB_GPIO_RESET;
         usb_pad_out_q <= '0;
         usb_pad_oe_q <= '0;
         usb_ctrl_in_q <= '0;
         usb_gpio_in_q <= '0;
         test_pins_free_q <= 1'b0;
         analog_available_q <= 1'b0;
      end
      else
      begin
         pad_q <= pad_d;
         main_in_q <= owns_d ? '0 : pad_sync_q;
         main_selector_active_q <= ~deep_sleep; // RULE1
         low_power_general_io_in_q <= gpio_in_d;
         lpuart_in_q <= uart_d;
         lp_twowire_data_in_q <= sda_d;
         lp_twowire_clock_in_q <= scl_d;
         usb_gpio_q <= usb_gpio_d;
         usb_pad_out_q <= usb_pad_out_d;
         usb_pad_oe_q <= usb_pad_oe_d;
         usb_ctrl_in_q <= usb_gpio_q ? 2'h0 : usb_sync_q;
         usb_gpio_in_q <= usb_gpio_q ? usb_sync_q : 2'h0;
         // debug over usb only while the pads still belong to the controller
         test_pins_free_q <= debug_from_usb & ~usb_gpio_q; // RULE11
         analog_available_q <= 1'b1; // RULE12
      end
   end

endmodule // low_power_pin_function_mux

// ### logic/lp_pin_defines.svh
// Behaviour
// RULE1: In deepest sleep the main pin selector is idle and this selector alone routes the pins.
// RULE2: Each low-power pin connects exactly one of its candidate signals, also in deep sleep.
// RULE3: The general-purpose select makes the pin a general IO of the low-power processor.
// RULE4: A peripheral select connects the pin to its UART or two-wire signal, not the general IO.
// RULE5: Select F0 puts DTR, DSR, RTS, CTS, RX and TX on pins 0 to 5; pin 6 has no F0 use.
// RULE6: Select F1 makes pins 0 to 6 general IOs, F3 puts data on pin 2 and clock on pin 3.
// RULE7: The per-pin selects sit in registers indexed by low-power IO number.
// RULE8: Software never enables UART flow control together with the two-wire bus.
// RULE9: After reset the USB data pins belong to the USB controller until reconfigured.
// RULE10: Software never enables the SDIO slave together with the USB controller.
// RULE11: The debug port may come from the USB pins, which frees the dedicated test pins.
// RULE12: Analog functions stay available in every power mode.
// RULE13: An unselected input function sees a constant 1 for pull-high, 0 for pull-low.
// RULE14: An unassigned select leaves the pad tri-stated and feeds no peripheral input.
`ifndef LP_PIN_DEFINES_SVH
`define LP_PIN_DEFINES_SVH

// ----------------------------------------
// function select codes
// ----------------------------------------
`define LP_SEL_UART 2'h0
`define LP_SEL_GPIO 2'h1
`define LP_SEL_NONE 2'h2
`define LP_SEL_TWI 2'h3
`define LP_SEL_RESET 2'h2

// ----------------------------------------
// pin positions and widths
// ----------------------------------------
`define LP_PIN_COUNT 7
`define LP_PIN_DTR 0
`define LP_PIN_DSR 1
`define LP_PIN_RTS 2
`define LP_PIN_CTS 3
`define LP_PIN_RXD 4
`define LP_PIN_TXD 5
`define LP_PIN_SDA 2
`define LP_PIN_SCL 3
`define LP_USB_GPIO_RESET 1'b0

`endif

// ### logic/lp_pin_pkg.sv
`include "lp_pin_defines.svh"
package lp_pin_pkg;
   typedef enum logic [1:0]
   {
      SEL_UART = `LP_SEL_UART,
      SEL_GPIO = `LP_SEL_GPIO,
      SEL_NONE = `LP_SEL_NONE,
      SEL_TWI = `LP_SEL_TWI
   } lp_sel_e;

   // pad drive bundle, one bit per pin
   typedef struct packed
   {
      logic [`LP_PIN_COUNT-1:0] out;
      logic [`LP_PIN_COUNT-1:0] oe;
   } pad_drive_s;

   // uart inputs seen by the low-power uart
   typedef struct packed
   {
      logic set_ready_n;
      logic clear_send_n;
      logic receive_line;
   } uart_in_s;
endpackage

// ### sim/lp_mux_properties.sv
`timescale 1ns/1ps
module lp_mux_properties
   import lp_pin_pkg::*;
(
   // clock, reset, power
   input wire logic clk,
   input wire logic nrst,
   input wire logic deep_sleep,
   input wire logic lp_claim,
   // configuration
   input wire logic cfg_we,
   input wire logic [2:0] cfg_index,
   input wire logic [1:0] cfg_func,
   input wire logic usb_cfg_we,
   input wire logic usb_cfg_gpio,
   input wire logic debug_from_usb,
   // pads and sources
   input wire logic [6:0] pad_in,
   input wire pad_drive_s pad_q,
   input wire pad_drive_s main_drive,
   input wire pad_drive_s low_power_general_io,
   input wire logic lpuart_transmit_line,
   input wire logic lp_twowire_data_low,
   input wire logic [1:0] usb_ctrl_oe,
   // observed results
   input wire logic main_selector_active_q,
   input wire uart_in_s lpuart_in_q,
   input wire logic [1:0] usb_pad_oe_q,
   input wire logic test_pins_free_q,
   input wire logic analog_available_q
);
   logic [6:0][1:0] sel_q;
   logic usb_gpio_q;
   wire owned = deep_sleep | lp_claim;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------------------------------
   // shadow of the select registers
   // ------------------------------
   // index 7 is dropped so a write there cannot alias onto a real pin
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_q <= 14'h2aaa;
         usb_gpio_q <= 1'b0;
      end
      else
      begin
         if (cfg_we && cfg_index != 3'h7)
            sel_q[cfg_index] <= cfg_func;
         if (usb_cfg_we)
            usb_gpio_q <= usb_cfg_gpio;
      end
   end
   // ------------------------------
   // properties
   // ------------------------------
   property p_sleep; deep_sleep |=> !main_selector_active_q; endproperty
   a_sleep: assert property (p_sleep) else $error("main selector active in sleep");
   property p_main; !owned |=> pad_q == $past(main_drive); endproperty
   a_main: assert property (p_main) else $error("pads not on main drive");
   property p_tx;
      owned && sel_q[5] == 2'h0 |=> pad_q.oe[5] && pad_q.out[5] == $past(lpuart_transmit_line);
   endproperty
   a_tx: assert property (p_tx) else $error("transmit pin wrong");
   property p_gpio;
      owned && sel_q[0] == 2'h1 |=>
         pad_q.out[0] == $past(low_power_general_io.out[0]) &&
         pad_q.oe[0] == $past(low_power_general_io.oe[0]);
   endproperty
   a_gpio: assert property (p_gpio) else $error("general io pin wrong");
   property p_twi;
      owned && sel_q[2] == 2'h3 |=> !pad_q.out[2] && pad_q.oe[2] == $past(lp_twowire_data_low);
   endproperty
   a_twi: assert property (p_twi) else $error("two-wire data pin wrong");
   property p_pin6; owned && sel_q[6] != 2'h1 |=> !pad_q.oe[6]; endproperty
   a_pin6: assert property (p_pin6) else $error("pin 6 driven without function");
   property p_unsel; sel_q[4] != 2'h0 |=> lpuart_in_q.receive_line; endproperty
   a_unsel: assert property (p_unsel) else $error("unselected receive not high");
   property p_rx;
      (owned && sel_q[4] == 2'h0) [*3] |=> lpuart_in_q.receive_line == $past(pad_in[4], 3);
   endproperty
   a_rx: assert property (p_rx) else $error("receive path wrong");
   property p_usb; !usb_gpio_q |=> usb_pad_oe_q == $past(usb_ctrl_oe); endproperty
   a_usb: assert property (p_usb) else $error("usb pads not on controller");
   property p_debug; debug_from_usb && !usb_gpio_q |=> test_pins_free_q; endproperty
   a_debug: assert property (p_debug) else $error("test pins not freed");
   property p_analog; 1'b1 |=> analog_available_q; endproperty
   a_analog: assert property (p_analog) else $error("analog not available");
   c_rx: cover property ((owned && sel_q[4] == 2'h0) [*3]);
   c_wake: cover property (!owned);
   c_usb: cover property (usb_cfg_we && usb_cfg_gpio);
endmodule // lp_mux_properties

// ### sim/lp_pad_model.sv
`timescale 1ns/1ps
module lp_pad_model
   import lp_pin_pkg::*;
(
   // design drive and board drive
   input wire pad_drive_s pad_q,
   input wire logic [6:0] ext_en,
   input wire logic [6:0] ext_val,
   // resolved pad level
   output logic [6:0] pad_in
);
   // a released pad takes the board level, or its weak pull-up when the board does not drive it; never keeps the old level
   always_comb
   begin
      for (int i = 0; i < 7; i++)
         pad_in[i] = pad_q.oe[i] ? pad_q.out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
   end
endmodule // lp_pad_model

// ### sim/tb_low_power_pin_function_mux.sv
`timescale 1ns/1ps
module tb_low_power_pin_function_mux;
   import lp_pin_pkg::*;
   logic clk, nrst, deep_sleep, lp_claim, cfg_we, usb_cfg_we, usb_cfg_gpio, debug_from_usb;
   logic [2:0] cfg_index;
   logic [1:0] cfg_func, usb_pad_in, usb_ctrl_out, usb_ctrl_oe, usb_gpio_out, usb_gpio_oe;
   logic [1:0] usb_pad_out_q, usb_pad_oe_q, usb_ctrl_in_q, usb_gpio_in_q;
   logic [6:0] pad_in, main_in_q, low_power_general_io_in_q, ext_val;
   pad_drive_s pad_q, main_drive, low_power_general_io;
   logic main_selector_active_q, lpuart_terminal_ready_n, lpuart_request_send_n;
   logic lpuart_transmit_line, lp_twowire_data_low, lp_twowire_clock_low;
   logic lp_twowire_data_in_q, lp_twowire_clock_in_q, test_pins_free_q, analog_available_q;
   uart_in_s lpuart_in_q;
   int miscompares, checks, cyc;
   logic [7:0] usb_view;
   // usb outputs gathered so one compare covers all four
   assign usb_view = {usb_pad_oe_q, usb_pad_out_q, usb_ctrl_in_q, usb_gpio_in_q};
   low_power_pin_function_mux low_power_pin_function_mux_inst (.clk, .nrst, .deep_sleep,
      .lp_claim, .cfg_we, .cfg_index, .cfg_func, .usb_cfg_we, .usb_cfg_gpio, .debug_from_usb,
      .pad_in, .pad_q, .main_drive, .main_in_q, .main_selector_active_q, .low_power_general_io,
      .low_power_general_io_in_q, .lpuart_terminal_ready_n, .lpuart_request_send_n,
      .lpuart_transmit_line, .lpuart_in_q, .lp_twowire_data_low, .lp_twowire_clock_low,
      .lp_twowire_data_in_q, .lp_twowire_clock_in_q, .usb_pad_in, .usb_ctrl_out, .usb_ctrl_oe,
      .usb_gpio_out, .usb_gpio_oe, .usb_pad_out_q, .usb_pad_oe_q, .usb_ctrl_in_q,
      .usb_gpio_in_q, .test_pins_free_q, .analog_available_q);
   // pin 3 has no board driver so it rests on its pull-up
   lp_pad_model lp_pad_model_inst (.pad_q, .ext_en(7'h77), .ext_val, .pad_in);
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         miscompares++;
         finish_test;
      end
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task automatic settle;
      repeat (5) @(negedge clk);
   endtask
   task automatic set_sel(logic [2:0] i, logic [1:0] f);
   begin
      @(negedge clk);
      cfg_we = 1'b1;
      cfg_index = i;
      cfg_func = f;
      @(negedge clk);
      cfg_we = 1'b0;
   end
   endtask
   task automatic do_reset;
   begin
      nrst = 1'b0;
      repeat (16) @(negedge clk);
      check("reset pads", pad_q, 16'h0000);
      check("reset uart in", lpuart_in_q, 16'h0007);
      nrst = 1'b1;
      settle;
      check("idle oe", pad_q.oe, 16'h0000);
      check("analog", analog_available_q, 16'h0001);
   end
   endtask
   task automatic t_uart;
   begin
      for (int i = 0; i < 7; i++)
         set_sel(3'(i), 2'h0);
      // levels 1, 0, 1 on dtr, rts, tx so a stuck pin shows
      {lpuart_terminal_ready_n, lpuart_request_send_n, lpuart_transmit_line} = 3'h5;
      settle;
      check("uart oe", pad_q.oe, 16'h0025);
      check("uart out", pad_q.out & 7'h25, 16'h0021);
      check("uart in", lpuart_in_q, 16'h0002);
      check("main off", {main_selector_active_q, main_in_q}, 16'h0000);
      $display("uart test done");
   end
   endtask
   task automatic t_gpio;
   begin
      for (int i = 0; i < 7; i++)
         set_sel(3'(i), 2'h1);
      low_power_general_io = {7'h55, 7'h0f};
      ext_val = 7'h50;
      settle;
      check("gpio pad", pad_q, {7'h55, 7'h0f});
      check("gpio in", low_power_general_io_in_q, 16'h0055);
      check("idle ins", {lpuart_in_q, lp_twowire_data_in_q, lp_twowire_clock_in_q},
         16'h001f);
      $display("gpio test done");
   end
   endtask
   task automatic t_twi;
   begin
      // two-wire takes pins 2 and 3, so flow control stays off
      set_sel(3'h2, 2'h3);
      set_sel(3'h3, 2'h3);
      set_sel(3'h0, 2'h2);
      set_sel(3'h7, 2'h1);
      lp_twowire_data_low = 1'b1;
      settle;
      check("twi oe", pad_q.oe, 16'h0006);
      check("twi out", pad_q.out[3:2], 16'h0000);
      check("twi in", {lp_twowire_data_in_q, lp_twowire_clock_in_q}, 16'h0001);
      check("twi gpio in", low_power_general_io_in_q, 16'h0050);
      lp_twowire_clock_low = 1'b1;
      settle;
      check("twi clock", {pad_q.oe[3], pad_q.out[3], lp_twowire_clock_in_q}, 16'h0004);
      lp_twowire_clock_low = 1'b0;
      $display("two-wire test done");
   end
   endtask
   task automatic t_wake;
   begin
      deep_sleep = 1'b0;
      settle;
      check("main pad", pad_q, {7'h3c, 7'h7f});
      check("main in", {main_selector_active_q, main_in_q}, 16'h00bc);
      lp_claim = 1'b1;
      settle;
      check("claimed", pad_q.oe, 16'h0006);
      deep_sleep = 1'b1;
      lp_claim = 1'b0;
      $display("wake test done");
   end
   endtask
   task automatic t_usb;
   begin
      debug_from_usb = 1'b0;
      settle;
      check("test kept", test_pins_free_q, 16'h0000);
      debug_from_usb = 1'b1;
      // no sdio slave in this bench, so the usb controller keeps its pads
      settle;
      check("usb ctrl", usb_view, 16'h00e4);
      check("test free", test_pins_free_q, 16'h0001);
      usb_cfg_we = 1'b1;
      usb_cfg_gpio = 1'b1;
      @(negedge clk);
      usb_cfg_we = 1'b0;
      settle;
      check("usb gpio", usb_view, 16'h0051);
      check("test held", test_pins_free_q, 16'h0000);
      do_reset;
      check("usb back", usb_pad_oe_q, 16'h0003);
      $display("usb test done");
   end
   endtask
   task automatic finish_test;
   begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // main sequence, inputs change on falling edges only
   initial
   begin
      {nrst, lp_claim, cfg_we, usb_cfg_we, usb_cfg_gpio, cfg_index, cfg_func} = '0;
      {lpuart_terminal_ready_n, lpuart_transmit_line, lp_twowire_clock_low} = '0;
      {lpuart_request_send_n, lp_twowire_data_low, ext_val, low_power_general_io} = '0;
      {deep_sleep, debug_from_usb} = 2'h3;
      main_drive = {7'h3c, 7'h7f};
      {usb_pad_in, usb_ctrl_out, usb_ctrl_oe, usb_gpio_out, usb_gpio_oe} = 10'h1b5;
      do_reset;
      t_uart;
      t_gpio;
      t_twi;
      t_wake;
      t_usb;
      finish_test;
   end
endmodule // tb_low_power_pin_function_mux

bind low_power_pin_function_mux lp_mux_properties lp_mux_properties_inst (.clk, .nrst,
   .deep_sleep, .lp_claim, .cfg_we, .cfg_index, .cfg_func, .usb_cfg_we, .usb_cfg_gpio,
   .debug_from_usb, .pad_in, .pad_q, .main_drive, .low_power_general_io, .lpuart_transmit_line,
   .lp_twowire_data_low, .usb_ctrl_oe, .main_selector_active_q, .lpuart_in_q, .usb_pad_oe_q,
   .test_pins_free_q, .analog_available_q);
